// File: dv/sdadc_bitstream_model.sv
`timescale 1ns/10ps
module sdadc_bitstream_model (
    input  wire logic       conv_clk_in,
    input  wire logic       rstn_in,
    input  wire logic [7:0] level_in,
    output logic            bit_out
);
    logic [8:0] acc_reg;
    // first-order loop: ones density follows level_in/256, frozen low only when level_in is 0
    always_ff @(posedge conv_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_reg <= 9'h000;
        end else begin
            acc_reg <= {1'h0, acc_reg[7:0]} + {1'h0, level_in};
        end
    end
    assign bit_out = acc_reg[8];
endmodule

// File: dv/sdadc_sequencer_asserts.sv
`timescale 1ns/10ps
module sdadc_sequencer_asserts #(parameter int unsigned NUM_AIN = 16) (
    input wire logic                         mclk_in,
    input wire logic                         rstn_in,
    input wire sdadc_pkg::sdadc_config_t     config_in,
    input wire sdadc_pkg::sdadc_per_channel_config_t [NUM_AIN-1:0] per_channel_config_in,
    input wire logic                         temp_en_in,
    input wire logic                         trigger_in,
    input wire logic                         data_read_in,
    input wire logic                         power_down_out,
    input wire logic [4:0]                   input_select_out,
    input wire logic [2:0]                   gain_stage_out,
    input wire logic [31:0]                  data_word_out,
    input wire logic                         busy_out,
    input wire logic                         irq_out
);
    logic any_en;
    // diff enable only counts on the even channel of a pair
    always_comb begin
        any_en = temp_en_in;
        for (int i = 0; i < NUM_AIN; i++) begin
            any_en = any_en | per_channel_config_in[i].se_en | (per_channel_config_in[i].diff_en & (i % 2 == 0));
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    property p_pd; power_down_out == !config_in.enable; endproperty
    a_pd: assert property (p_pd) else $error("power down level wrong");
    property p_gain; busy_out && input_select_out < 5'h10
        |-> gain_stage_out == per_channel_config_in[input_select_out[3:0]].gain; endproperty
    a_gain: assert property (p_gain) else $error("gain not from channel");
    property p_start; !busy_out && trigger_in && config_in.enable && any_en |=> busy_out;
    endproperty
    a_start: assert property (p_start) else $error("trigger not taken");
    property p_refuse; !busy_out && !(config_in.enable && any_en) |=> !busy_out; endproperty
    a_refuse: assert property (p_refuse) else $error("started with nothing");
    property p_irq_hold; irq_out && !data_read_in |=> irq_out; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
    property p_irq_clr; $fell(irq_out) |-> $past(data_read_in); endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq fell unread");
    property p_sweep_irq; $fell(busy_out) && config_in.enable |-> ##[0:2] irq_out; endproperty
    a_sweep_irq: assert property (p_sweep_irq) else $error("no irq after sweep");
    property p_fmt; data_word_out[31:21] == 11'h000 && data_word_out[15:12] == 4'h0; endproperty
    a_fmt: assert property (p_fmt) else $error("data word spare bits set");
endmodule

// File: dv/sdadc_sequencer_tb_top.sv
`timescale 1ns/10ps
module sdadc_sequencer_tb_top;
    logic                              mclk_in = 1'h0;
    logic                              rstn_in = 1'h0;
    logic                              temp_en_in = 1'h0;
    logic                              trigger_in = 1'h0;
    logic                              data_read_in = 1'h0;
    sdadc_pkg::sdadc_config_t          config_in = '0;
    sdadc_pkg::sdadc_per_channel_config_t [15:0] per_channel_config_in = '0;
    logic                              bit_w, conv_w, pd_w, busy_w, irq_w;
    logic [4:0]                        sel_w;
    logic [2:0]                        gain_w;
    logic [31:0]                       dw_w;
    logic [31:0]                       last_dw = 32'h0;
    logic [15:0][11:0]                 cd_w;
    logic [7:0]                        level = 8'h00;
    logic [5:0]                        note;
    logic [3:0]                        idx;
    logic [5:0]                        q[$];
    int                                n_fail = 0;
    int                                compares = 0;
    int                                seed = 32'ha55b94ea;

    initial forever #4 mclk_in = ~mclk_in;
    sdadc_sequencer uut (.mclk_in, .rstn_in, .config_in, .per_channel_config_in, .temp_en_in, .trigger_in,
        .data_read_in, .bitstream_in(bit_w), .conv_clk_out(conv_w), .power_down_out(pd_w),
        .input_select_out(sel_w), .diff_mode_out(), .gain_stage_out(gain_w),
        .data_word_out(dw_w), .chan_data_out(cd_w), .busy_out(busy_w), .irq_out(irq_w));
    sdadc_bitstream_model u_mod (.conv_clk_in(conv_w), .rstn_in, .level_in(level), .bit_out(bit_w));

    task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic pulse(logic rd);
        @(posedge mclk_in);
        data_read_in <= rd;
        trigger_in <= !rd;
        @(posedge mclk_in);
        data_read_in <= 1'h0;
        trigger_in <= 1'h0;
    endtask
    // waits until only `left` notes remain, and the sweep has ended when none remain
    task automatic wait_q(int left);
        for (int n = 0; n < 4000; n++) begin
            @(negedge mclk_in);
            if (q.size() <= left && (left > 0 || busy_w === 1'h0)) return;
        end
        check("wait limit", 12'h1, 12'h0);
        wrap_up();
    endtask

    // a store shows as a change of the data word, which always carries the slot
    always @(negedge mclk_in) begin
        if (rstn_in && busy_w === 1'h1 && sel_w < 5'h18) begin
            idx = sel_w[4] ? {sel_w[2:0], 1'h0} : sel_w[3:0];
            check("gain", 12'(gain_w), 12'(per_channel_config_in[idx].gain));
        end
        if (rstn_in && dw_w !== last_dw) begin
            last_dw = dw_w;
            if (q.size() == 0) begin
                check("stray result", 12'h1, 12'h0);
            end else begin
                note = q.pop_front();
                idx = note[4] ? {note[2:0], 1'h0} : note[3:0];
                check("slot", 12'(dw_w[20:16]), 12'(note[4:0]));
                check("sign", 12'(dw_w[11]), 12'(note[5]));
                if (note[4:0] != 5'h18) check("channel word", cd_w[idx], dw_w[11:0]);
            end
        end
    end

    initial begin
        for (int i = 0; i < 16; i++) per_channel_config_in[i].gain = 3'(($random(seed) & 32'hff) % 6);
        repeat (6) @(posedge mclk_in);
        rstn_in <= 1'h1;
        config_in <= '{1'h1, 1'h1, 8'h0f, 8'h00, 8'h01};
        per_channel_config_in[2].se_en <= 1'h1;
        per_channel_config_in[2].diff_en <= 1'h1;
        per_channel_config_in[5].se_en <= 1'h1;
        per_channel_config_in[5].sinc_filter_select <= 1'h1;
        temp_en_in <= 1'h1;
        q = '{6'h22, 6'h25, 6'h31, 6'h38};
        @(negedge mclk_in);
        check("idle flags", 12'({busy_w, irq_w}), 12'h0);
        pulse(1'h0);
        repeat (20) @(posedge mclk_in);
        pulse(1'h0);
        wait_q(0);
        repeat (200) @(posedge mclk_in);
        check("sweep irq", 12'(irq_w), 12'h1);
        pulse(1'h1);
        @(negedge mclk_in);
        check("irq cleared", 12'(irq_w), 12'h0);
        // continuous: sinc off, since it carries history across channels
        @(posedge mclk_in);
        per_channel_config_in[2].se_en <= 1'h0;
        per_channel_config_in[2].diff_en <= 1'h0;
        per_channel_config_in[5].se_en <= 1'h0;
        per_channel_config_in[5].sinc_filter_select <= 1'h0;
        per_channel_config_in[0].se_en <= 1'h1;
        config_in.single_sweep <= 1'h0;
        level <= 8'hff;
        q = '{6'h00, 6'h18, 6'h00, 6'h18};
        pulse(1'h0);
        wait_q(1);
        @(posedge mclk_in);
        config_in.single_sweep <= 1'h1;
        wait_q(0);
        pulse(1'h1);
        @(posedge mclk_in);
        per_channel_config_in[0].se_en <= 1'h0;
        temp_en_in <= 1'h0;
        pulse(1'h0);
        repeat (10) @(negedge mclk_in);
        check("busy no channel", 12'(busy_w), 12'h0);
        @(posedge mclk_in);
        config_in.enable <= 1'h0;
        @(negedge mclk_in);
        check("power down", 12'(pd_w), 12'h1);
        wrap_up();
    end
endmodule

bind sdadc_sequencer sdadc_sequencer_asserts #(.NUM_AIN(NUM_AIN)) u_chk (.mclk_in, .rstn_in,
    .config_in, .per_channel_config_in, .temp_en_in, .trigger_in, .data_read_in, .power_down_out,
    .input_select_out, .gain_stage_out, .data_word_out, .busy_out, .irq_out);

// File: logic/sdadc_pkg.sv
package sdadc_pkg;
    localparam int unsigned NUM_AIN        = 16;
    localparam int unsigned NUM_DIFF       = 8;
    localparam int unsigned NUM_SLOTS      = 25;
    localparam int unsigned TEMP_SLOT      = 24;
    localparam int unsigned RESULT_W       = 12;
    localparam int unsigned DATA_W         = 32;
    localparam int unsigned GAIN_W         = 3;
    localparam int unsigned OSR_W          = 8;
    localparam int unsigned DLY_W          = 8;
    localparam int unsigned CLKDIV_W       = 8;
    localparam int unsigned SETTLE_UNIT    = 25;
    localparam int unsigned ACC_W          = 32;
    localparam logic [7:0]  OSR_RESET      = 8'h7f;
    localparam logic [7:0]  CLKDIV_RESET   = 8'h04;
    localparam logic [7:0]  DLY_RESET      = 8'h00;
    localparam logic [11:0] RESULT_MIN     = 12'h800;
    localparam logic [11:0] RESULT_MAX     = 12'h7ff;
    localparam logic [2:0]  GAIN_HALF      = 3'h0;
    localparam logic [2:0]  GAIN_MAX_CODE  = 3'h5;

    // one channel's setting: gain code 0..5 = 0.5,1,2,4,8,16 V/V
    typedef struct packed {
        logic             se_en;
        logic             diff_en;
        logic             sinc_filter_select;
        logic [2:0]       gain;
    } sdadc_per_channel_config_t;

    typedef struct packed {
        logic             enable;
        logic             single_sweep;
        logic [7:0]       osr;
        logic [7:0]       clk_div;
        logic [7:0]       channel_settle_delay;
    } sdadc_config_t;

    typedef struct packed {
        logic [4:0]       slot;
        logic [11:0]      value;
    } sdadc_result_t;
endpackage

// File: logic/sdadc_sequencer.sv
`timescale 1ns/10ps
// Function
// [R1] results are 12-bit values carried in a 32-bit data word
// [R2] sixteen inputs, single-ended or up to eight differential pairs, mixed
// [R3] temperature sensor is a seventeenth selectable channel
// [R4] each channel holds its own gain code for 0.5 to 16 V/V
// [R5] clearing the enable bit puts the converter in power-down
// [R6] a new result overwrites the stored one; software reads it first
// [R7] writing the trigger field starts the conversion process
// [R8] converter clock is divided from the system clock
// [R9] single-sweep mode converts enabled channels once per trigger then idles
// [R10] continuous mode wraps from last enabled channel to the first
// [R11] continuous mode restarts each sweep without a trigger
// [R12] order: single-ended, then differential, then temperature
// [R13] programmable settle delay between channel switch and accumulation
// [R14] differential result overwrites single-ended result for the same channel
// [R15] interrupt after each completed sweep in both modes
// [R16] integrator cascade filter by default, sinc when channel bit set
// [R17] software should avoid the sinc filter in continuous mode
// [R18] integrator cascade filter cleared at every conversion start
// [R19] sinc filter keeps state across conversions, four stages
// [R20] results are two's complement from 0x800 up to 0x7ff
// [R21] interrupt held until data or status is read
// [R22] disabled channels skipped; trigger with nothing enabled does nothing
module sdadc_sequencer #(
    parameter int unsigned NUM_AIN = sdadc_pkg::NUM_AIN
) (
    input  wire logic                                mclk_in,
    input  wire logic                                rstn_in,
    input  wire sdadc_pkg::sdadc_config_t            config_in,
    input  wire sdadc_pkg::sdadc_per_channel_config_t [NUM_AIN-1:0] per_channel_config_in,
    input  wire logic                                temp_en_in,
    input  wire logic                                trigger_in,
    input  wire logic                                data_read_in,
    input  wire logic                                bitstream_in,
    output logic                                     conv_clk_out,
    output logic                                     power_down_out,
    output logic [4:0]                               input_select_out,
    output logic                                     diff_mode_out,
    output logic [2:0]                               gain_stage_out,
    output logic [31:0]                              data_word_out,
    output logic [NUM_AIN-1:0][11:0]                 chan_data_out,
    output logic                                     busy_out,
    output logic                                     irq_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONVERT, ST_STORE} sdadc_state_t;

    sdadc_state_t   state_reg;
    logic [7:0]     div_cnt_reg;
    logic           conv_clk_reg;
    logic           tick;
    logic [4:0]     slot_reg;
    logic [15:0]    settle_cnt_reg;
    logic [7:0]     osr_cnt_reg;
    logic [31:0]    int1_reg, int2_reg, int3_reg;
    logic [31:0]    sinc_reg [4];
    logic [24:0]    slot_en;
    logic [4:0]     first_slot;
    logic           any_en;
    logic [4:0]     next_slot;
    logic           next_found;
    logic           cur_sinc;
    logic [31:0]    raw;
    logic [11:0]    scaled;
    logic           start;
    logic           rewrap;
    logic           settle_done;
    logic [15:0]    settle_load;
    logic [31:0]    step;

    // slots 0..15 single-ended, 16..23 differential pairs, 24 temperature
    genvar g;
    generate
        for (g = 0; g < sdadc_pkg::NUM_AIN; g++) begin : g_se_slot
            assign slot_en[g] = per_channel_config_in[g].se_en;
        end
        for (g = 0; g < sdadc_pkg::NUM_DIFF; g++) begin : g_diff_slot
            // the odd channel of a pair carries no enable of its own
            assign slot_en[sdadc_pkg::NUM_AIN+g] = per_channel_config_in[2*g].diff_en;      // [R2]
        end
    endgenerate
    assign slot_en[sdadc_pkg::TEMP_SLOT] = temp_en_in;                             // [R3]

    // slot to channel: a differential pair reports on its even channel
    function automatic logic [3:0] chan_of(input logic [4:0] slot);
        logic [3:0] c;
        c = slot[3:0];
        if (slot >= 5'(sdadc_pkg::NUM_AIN)) begin
            c = {slot[2:0], 1'b0};
        end
        return c;
    endfunction

    function automatic logic is_diff(input logic [4:0] slot);
        return (slot >= 5'(sdadc_pkg::NUM_AIN)) && (slot < 5'(sdadc_pkg::TEMP_SLOT));
    endfunction

    function automatic logic is_temp(input logic [4:0] slot);
        return slot == 5'(sdadc_pkg::TEMP_SLOT);
    endfunction

    function automatic logic [5:0] find_from(input logic [24:0] en, input logic [4:0] from);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 24; i >= 0; i--) begin
            if (en[i] && (5'(i) >= from)) r = {1'b1, 5'(i)};
        end
        return r;
    endfunction

    always_comb begin
        {any_en, first_slot} = find_from(slot_en, 5'h00);                         // [R22]
        {next_found, next_slot} = find_from(slot_en, slot_reg + 5'h01);           // [R12]
    end

    always_comb begin
        cur_sinc = 1'b0;
        if (!is_temp(slot_reg)) begin
            cur_sinc = per_channel_config_in[chan_of(slot_reg)].sinc_filter_select;         // [R16]
        end
    end

    // converter clock from a free divider so it stays phase-locked to timers
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_cnt_reg  <= 8'h00;
            conv_clk_reg <= 1'b0;
        end else if (!config_in.enable) begin
            div_cnt_reg  <= 8'h00;                                                 // [R5]
            conv_clk_reg <= 1'b0;
        end else if (div_cnt_reg >= config_in.clk_div) begin
            div_cnt_reg  <= 8'h00;                                                 // [R8]
            conv_clk_reg <= ~conv_clk_reg;
        end else begin
            div_cnt_reg  <= div_cnt_reg + 8'h01;
        end
    end
    assign tick = config_in.enable && (div_cnt_reg >= config_in.clk_div) && conv_clk_reg;
    assign conv_clk_out   = conv_clk_reg;
    assign power_down_out = !config_in.enable;                                    // [R5]

    assign start       = trigger_in && any_en;                                     // [R7] [R22]
    assign rewrap      = !config_in.single_sweep && any_en;                        // [R10] [R11]
    assign settle_done = (settle_cnt_reg == 16'h0000);
    assign settle_load = 16'(config_in.channel_settle_delay) * 16'(sdadc_pkg::SETTLE_UNIT);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ST_IDLE;
        end else if (!config_in.enable) begin
            state_reg <= ST_IDLE;                                                  // [R5]
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin                                               // [R7] [R22]
                        state_reg <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (tick && settle_done) begin                                 // [R13]
                        state_reg <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (tick && (osr_cnt_reg == 8'h00)) begin
                        state_reg <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    if (next_found || rewrap) begin                                // [R11]
                        state_reg <= ST_SETTLE;
                    end else begin
                        state_reg <= ST_IDLE;                                      // [R9]
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // slot only moves while enabled, so a power-down keeps the last selection
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            slot_reg <= 5'h00;
        end else if (config_in.enable) begin
            if ((state_reg == ST_IDLE) && start) begin
                slot_reg <= first_slot;
            end else if ((state_reg == ST_STORE) && next_found) begin
                slot_reg <= next_slot;                                             // [R12] [R22]
            end else if ((state_reg == ST_STORE) && rewrap) begin
                slot_reg <= first_slot;                                            // [R10]
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            settle_cnt_reg <= 16'h0000;
        end else if (config_in.enable) begin
            if (((state_reg == ST_IDLE) && start) || (state_reg == ST_STORE)) begin
                settle_cnt_reg <= settle_load;
            end else if ((state_reg == ST_SETTLE) && tick && !settle_done) begin
                settle_cnt_reg <= settle_cnt_reg - 16'h0001;                       // [R13]
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            osr_cnt_reg <= 8'h00;
        end else if (config_in.enable) begin
            if ((state_reg == ST_SETTLE) && tick && settle_done) begin
                osr_cnt_reg <= config_in.osr;
            end else if ((state_reg == ST_CONVERT) && tick && (osr_cnt_reg != 8'h00)) begin
                osr_cnt_reg <= osr_cnt_reg - 8'h01;
            end
        end
    end

    // decimation: bit maps to +1/-1 so 50% ones reads as zero
    assign step = bitstream_in ? 32'h00000001 : 32'hffffffff;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            int1_reg <= 32'h0;
            int2_reg <= 32'h0;
            int3_reg <= 32'h0;
        end else if (state_reg == ST_SETTLE) begin
            // cleared per conversion so channels stay independent
            int1_reg <= 32'h0;                                                     // [R18]
            int2_reg <= 32'h0;
            int3_reg <= 32'h0;
        end else if ((state_reg == ST_CONVERT) && tick && !cur_sinc) begin
            int1_reg <= int1_reg + step;                                           // [R16]
            int2_reg <= int2_reg + int1_reg;
            int3_reg <= int3_reg + int2_reg;
        end
    end

    // recursive stages are never cleared between conversions
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sinc_reg[0] <= 32'h0;
        end else if ((state_reg == ST_CONVERT) && tick && cur_sinc) begin
            sinc_reg[0] <= sinc_reg[0] + step;                                     // [R19]
        end
    end

    generate
        for (g = 1; g < 4; g++) begin : g_sinc_stage
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    sinc_reg[g] <= 32'h0;
                end else if ((state_reg == ST_CONVERT) && tick && cur_sinc) begin
                    sinc_reg[g] <= sinc_reg[g] + sinc_reg[g-1];                    // [R19]
                end
            end
        end
    endgenerate

    assign raw = cur_sinc ? sinc_reg[0] : int1_reg;                               // [R16]
    always_comb begin
        // saturate to the signed 12-bit range rather than wrap
        scaled = raw[11:0];                                                        // [R20]
        if ($signed(raw) > $signed({20'h0, sdadc_pkg::RESULT_MAX})) begin
            scaled = sdadc_pkg::RESULT_MAX;
        end else if ($signed(raw) < $signed({20'hfffff, sdadc_pkg::RESULT_MIN})) begin
            scaled = sdadc_pkg::RESULT_MIN;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            data_word_out <= 32'h0;
            chan_data_out <= '0;
        end else if (state_reg == ST_STORE) begin
            data_word_out <= {11'h0, slot_reg, 4'h0, scaled};                     // [R1] [R6]
            if (!is_temp(slot_reg)) begin
                // differential slots come later, so they land on top of se data
                chan_data_out[chan_of(slot_reg)] <= scaled;                        // [R14]
            end
        end
    end

    // set wins: a sweep ending in the read cycle must not be lost
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
        end else if ((state_reg == ST_STORE) && !next_found) begin
            irq_out <= 1'b1;                                                       // [R15]
        end else if (data_read_in) begin
            irq_out <= 1'b0;                                                       // [R21]
        end
    end

    assign input_select_out = slot_reg;
    assign diff_mode_out    = is_diff(slot_reg);                                   // [R2]
    assign busy_out         = (state_reg != ST_IDLE);

    always_comb begin
        gain_stage_out = sdadc_pkg::GAIN_HALF;
        if (!is_temp(slot_reg)) begin
            gain_stage_out = per_channel_config_in[chan_of(slot_reg)].gain;                  // [R4]
        end
    end
endmodule
